// >>> bench/spwm_monitor_asserts.sv
// checker for the monitor's port behaviour
`timescale 1ns/1ps
module spwm_monitor_asserts (
    // clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // wishbone
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // drive and status
    input wire torque_enable,
    input wire function_error_free_out,
    input wire max_position_active_status,
    input wire allow_pos_dir,
    input wire allow_neg_dir
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_answers_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    ack_has_req_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    dat_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    err_free_torque_a: assert property (function_error_free_out == torque_enable)
        else $error("error-free output differs from torque");
    active_needs_run_a: assert property (max_position_active_status |-> torque_enable)
        else $error("active status while faulted");
    one_dir_open_a: assert property (torque_enable |-> allow_pos_dir || allow_neg_dir)
        else $error("both directions blocked in run");
    fault_latched_a: assert property ($fell(torque_enable) |=> !torque_enable [*4])
        else $error("fault released without acknowledge");
endmodule
bind spwm_monitor spwm_monitor_asserts spwm_monitor_asserts_i (.*);

// >>> bench/spwm_partner.sv
// far-side model: safety controller pins and axis feedback
`timescale 1ns/1ps
module spwm_partner (
    // clock
    input wire clk_sys,
    // controller pins
    output reg limited_position_request,
    output reg position_trusted_status,
    output reg pulse_enable,
    output reg fault_ack,
    // axis feedback
    output reg [31:0] axis_position,
    output reg [31:0] axis_speed,
    output reg homing_done
);
    // idle levels before reset release
    initial
    begin
        limited_position_request = 1'b1;
        position_trusted_status = 1'b0;
        pulse_enable = 1'b0;
        fault_ack = 1'b0;
        axis_position = 32'h0;
        axis_speed = 32'h0;
        homing_done = 1'b0;
    end
    // safe-false level asks for the limited position function
    task req(input logic on);
    begin
        @(posedge clk_sys);
        limited_position_request <= !on;
    end
    endtask
    // acknowledge pulse, long enough for the pin synchroniser
    task ack;
    begin
        @(posedge clk_sys);
        fault_ack <= 1'b1;
        repeat (8) @(posedge clk_sys);
        fault_ack <= 1'b0;
        repeat (8) @(posedge clk_sys);
    end
    endtask
endmodule

// >>> bench/tb.sv
// self-checking bench for the position window monitor
`timescale 1ns/1ps
`include "spwm_map.vh"
module tb;
    reg clk_sys = 1'b0;
    reg sys_rst = 1'b1;
    reg wb_cyc_i = 1'b0;
    reg wb_stb_i = 1'b0;
    reg wb_we_i = 1'b0;
    reg [3:0] wb_sel_i = 4'h0;
    reg [7:0] wb_adr_i = 8'h0;
    reg [31:0] wb_dat_i = 32'h0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, lpr, pts, pen, fak, hd, te, fe, mpa, apd, and_, irq;
    wire [31:0] pos, spd;
    integer miscompares = 0;
    integer n_tests = 0;
    integer cycles = 0;
    logic [31:0] q;
    always #5 clk_sys = ~clk_sys;
    spwm_partner p (.clk_sys(clk_sys), .limited_position_request(lpr),
        .position_trusted_status(pts), .pulse_enable(pen), .fault_ack(fak),
        .axis_position(pos), .axis_speed(spd), .homing_done(hd));
    spwm_monitor #(.HOME_TMO_CYC(40'd200)) spwm_monitor_i (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .axis_position(pos), .axis_speed(spd), .homing_done(hd),
        .limited_position_request(lpr), .position_trusted_status(pts),
        .pulse_enable(pen), .fault_ack(fak), .torque_enable(te),
        .function_error_free_out(fe), .max_position_active_status(mpa),
        .allow_pos_dir(apd), .allow_neg_dir(and_), .irq(irq));
    task close_out;
    begin
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    // compare one value
    task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    // one classic wishbone cycle, held until ack is sampled
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        integer n;
    begin
        n = 0;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hf;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_sys);
        while (wb_ack_o !== 1'b1)
        begin
            @(posedge clk_sys);
            n++;
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        chk(n, 32'h1);
    end
    endtask
    // run at the given position and speed, check torque against ok, then release and acknowledge
    task viol(input logic [31:0] ps, input logic [31:0] sp, input logic ok);
    begin
        p.axis_position <= ps;
        p.axis_speed <= sp;
        p.req(1'b1);
        repeat (120) @(posedge clk_sys);
        chk(te, ok);
        p.req(1'b0);
        p.axis_position <= 32'd500;
        p.axis_speed <= 32'h0;
        p.ack;
        chk(te, 1'b1);
    end
    endtask
    // cut a hang short
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            close_out;
        end
    end
    initial
    begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        wb(0, `SPWM_ADR_DECEL, 0); chk(q, 32'd1073676289);
        wb(0, `SPWM_ADR_CTRL, 0); chk(q, 32'h0);
        wb(0, `SPWM_ADR_SMP_HI, 0); chk(q, 32'h0);
        wb(0, 8'h3c, 0); chk(q, 32'h0);
        wb(1, `SPWM_ADR_IRQ_EN, 32'h1);
        p.req(1'b1);
        repeat (12) @(posedge clk_sys);
        chk(fe, 1'b0);
        chk(irq, 1'b1);
        wb(1, `SPWM_ADR_IRQ_CLR, 32'h1);
        @(posedge clk_sys);
        chk(irq, 1'b0);
        p.req(1'b0);
        p.ack;
        chk(te, 1'b1);
        p.homing_done <= 1'b1;
        wb(1, `SPWM_ADR_SLP_HI, 32'd1000);
        wb(1, `SPWM_ADR_DECEL, 32'd1);
        viol(32'd200, 32'd40, 1'b1);
        viol(32'd200, 32'd41, 1'b0);
        viol(32'd200, 32'hffffffeb, 1'b0);
        viol(32'd1001, 32'h0, 1'b0);
        p.homing_done <= 1'b0;
        wb(1, `SPWM_ADR_SMP_HI, 32'd1000);
        wb(1, `SPWM_ADR_CTRL, 32'h1);
        p.pulse_enable <= 1'b1;
        repeat (230) @(posedge clk_sys);
        chk(te, 1'b0);
        p.homing_done <= 1'b1;
        p.ack;
        chk(mpa, 1'b1);
        p.position_trusted_status <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(fe, 1'b0);
        p.homing_done <= 1'b0;
        @(posedge clk_sys);
        p.homing_done <= 1'b1;
        p.ack;
        chk(mpa, 1'b1);
        p.axis_position <= 32'd1001;
        repeat (4) @(posedge clk_sys);
        chk(te, 1'b0);
        p.ack;
        chk({apd, and_}, 2'b01);
        p.axis_position <= 32'd1002;
        repeat (4) @(posedge clk_sys);
        chk(te, 1'b0);
        close_out;
    end
endmodule

// >>> common/spwm_map.vh
// register map, field positions, reset values and timing for the position window monitor
`ifndef SPWM_MAP_VH
`define SPWM_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SPWM_ADR_CTRL 8'h00
`define SPWM_ADR_DECEL 8'h04
`define SPWM_ADR_SLP_LO 8'h08
`define SPWM_ADR_SLP_HI 8'h0c
`define SPWM_ADR_SMP_LO 8'h10
`define SPWM_ADR_SMP_HI 8'h14
`define SPWM_ADR_SPD_TOL 8'h18
`define SPWM_ADR_POS_TOL 8'h1c
`define SPWM_ADR_SLP_DLY 8'h20
`define SPWM_ADR_RANGE 8'h24
`define SPWM_ADR_STATUS 8'h28
`define SPWM_ADR_IRQ_STAT 8'h2c
`define SPWM_ADR_IRQ_CLR 8'h30
`define SPWM_ADR_IRQ_EN 8'h34

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SPWM_CTRL_SMP_USED 0
`define SPWM_IRQ_FUNC 0
`define SPWM_IRQ_FS 1
`define SPWM_IRQ_ACK 2
`define SPWM_IRQ_TMO 3
`define SPWM_IRQ_W 4
`define SPWM_PIN_REQ 0
`define SPWM_PIN_TRUST 1
`define SPWM_PIN_PULSE 2
`define SPWM_PIN_ACK 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SPWM_RST_CTRL 1'b0
`define SPWM_RST_DECEL 32'h3fff0001
`define SPWM_RST_LIMIT 32'h00000000
`define SPWM_RST_TOL 32'h00000000
`define SPWM_RST_DLY 32'h00000000
`define SPWM_RST_RANGE 32'hffffffff
`define SPWM_RST_IRQ 4'h0
`define SPWM_RST_PINS 4'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SPWM_CLK_HZ 40'd100000000
`define SPWM_HOMING_TMO_MIN 40'd15
`define SPWM_SEC_PER_MIN 40'd60
`define SPWM_CYC_PER_US (`SPWM_CLK_HZ / 40'd1000000)

`endif

// >>> hw/spwm_isqrt.v
// sequential integer square root, one result bit per clock
`timescale 1ns/1ps
module spwm_isqrt #(
    parameter RW = 64
) (
    // clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // request
    input wire start,
    input wire [RW-1:0] radicand,
    // answer
    output reg busy,
    output reg done,
    output reg [RW/2-1:0] root
);

reg [RW-1:0] op_reg;
reg [RW-1:0] res_reg;
reg [RW-1:0] bit_reg;
reg [RW-1:0] trial;
reg [RW-1:0] res_next;

// trial subtraction for the current bit pair
always @*
begin
    trial = res_reg | bit_reg;
    if (op_reg >= trial)
        res_next = (res_reg >> 1) | bit_reg;
    else
        res_next = res_reg >> 1;
end

// iterate from the top bit pair down to bit zero
always @(posedge clk_sys or posedge sys_rst)
begin
    if (sys_rst)
    begin
        op_reg <= {RW{1'b0}};
        res_reg <= {RW{1'b0}};
        bit_reg <= {RW{1'b0}};
        busy <= 1'b0;
        done <= 1'b0;
        root <= {(RW/2){1'b0}};
    end
    else
    begin
        done <= 1'b0;
        if (start && !busy)
        begin
            op_reg <= radicand;
            res_reg <= {RW{1'b0}};
            bit_reg <= {2'b01, {(RW-2){1'b0}}};
            busy <= 1'b1;
        end
        else if (busy)
        begin
            if (op_reg >= trial)
                op_reg <= op_reg - trial;
            res_reg <= res_next;
            bit_reg <= bit_reg >> 2;
            if (bit_reg[0])
            begin
                busy <= 1'b0;
                done <= 1'b1;
                root <= res_next[RW/2-1:0];
            end
        end
    end
end

endmodule

// >>> hw/spwm_monitor.v
// safe position window monitor for one drive axis with wishbone configuration port
`timescale 1ns/1ps
`include "spwm_map.vh"
module spwm_monitor #(
    parameter [39:0] HOME_TMO_CYC = `SPWM_HOMING_TMO_MIN * `SPWM_SEC_PER_MIN * `SPWM_CLK_HZ
) (
    // clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // axis feedback, same clock domain
    input wire [31:0] axis_position,
    input wire [31:0] axis_speed,
    input wire homing_done,
    // pins from the safety controller and drive
    input wire limited_position_request,
    input wire position_trusted_status,
    input wire pulse_enable,
    input wire fault_ack,
    // drive and status outputs
    output reg torque_enable,
    output reg function_error_free_out,
    output reg max_position_active_status,
    output reg allow_pos_dir,
    output reg allow_neg_dir,
    output reg irq
);

localparam [1:0] MS_RUN = 2'h0;
localparam [1:0] MS_FFS = 2'h1;
localparam [1:0] MS_FS = 2'h2;

// ----------------------------------------------------------------
// configuration registers
// ----------------------------------------------------------------
reg ctrl_reg;
reg [31:0] decel_reg;
reg [31:0] slp_lo_reg;
reg [31:0] slp_hi_reg;
reg [31:0] smp_lo_reg;
reg [31:0] smp_hi_reg;
reg [31:0] spd_tol_reg;
reg [31:0] pos_tol_reg;
reg [31:0] slp_dly_reg;
reg [31:0] range_reg;
reg [3:0] irq_en_reg;
reg [3:0] irq_stat_reg;

// monitor state
reg [1:0] mon_state_reg;
reg [1:0] mon_state_next;
reg [3:0] pin_s1_reg;
reg [3:0] pin_s2_reg;
reg [3:0] pin_s3_reg;
reg [3:0] pin_reg;
reg [3:0] pin_prev_reg;
reg homed_prev_reg;
reg trust_changed_reg;
reg slp_arm_reg;
reg [38:0] slp_cnt_reg;
reg tmo_run_reg;
reg [39:0] tmo_cnt_reg;
reg restr_reg;
reg [1:0] ovr_reg;
reg [31:0] ref_pos_reg;
reg sq_go_reg;
reg sq_run_reg;
reg sq_phase_reg;
reg [31:0] spd_cap_reg;
reg slp_spd_flt_reg;
reg smp_spd_flt_reg;

wire sq_busy;
wire sq_done;
wire [31:0] sq_root;
wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
wire wb_wr = wb_req && wb_we_i;

// ----------------------------------------------------------------
// pin synchronisers and edges
// ----------------------------------------------------------------
wire [3:0] pin_agree = pin_s2_reg ~^ pin_s3_reg;
wire slp_req = !pin_reg[`SPWM_PIN_REQ];
wire slp_req_edge = slp_req && pin_prev_reg[`SPWM_PIN_REQ];
wire trust_evt = pin_reg[`SPWM_PIN_TRUST] != pin_prev_reg[`SPWM_PIN_TRUST];
wire pulse_edge = pin_reg[`SPWM_PIN_PULSE] && !pin_prev_reg[`SPWM_PIN_PULSE];
wire ack_edge = pin_reg[`SPWM_PIN_ACK] && !pin_prev_reg[`SPWM_PIN_ACK];
wire smp_used = ctrl_reg;
// start delay in clocks; the largest setting times the clock rate still fits 39 bits
wire [39:0] slp_dly_cyc = slp_dly_reg * `SPWM_CYC_PER_US;
wire homed_ok = homing_done && !trust_changed_reg;

// ----------------------------------------------------------------
// geometry: window checks and distances to the limits
// ----------------------------------------------------------------
wire [32:0] pos_x = {axis_position[31], axis_position};
wire [32:0] slp_up = {slp_hi_reg[31], slp_hi_reg} - pos_x;
wire [32:0] slp_dn = pos_x - {slp_lo_reg[31], slp_lo_reg};
wire [32:0] smp_up = {smp_hi_reg[31], smp_hi_reg} - pos_x;
wire [32:0] smp_dn = pos_x - {smp_lo_reg[31], smp_lo_reg};
wire [32:0] slp_wid = {slp_hi_reg[31], slp_hi_reg} - {slp_lo_reg[31], slp_lo_reg};
wire [32:0] smp_wid = {smp_hi_reg[31], smp_hi_reg} - {smp_lo_reg[31], smp_lo_reg};
wire slp_out = slp_up[32] || slp_dn[32];
wire smp_above = smp_up[32];
wire smp_below = smp_dn[32];
wire speed_up = !axis_speed[31] && (axis_speed != 32'h00000000);
wire [31:0] speed_mag = axis_speed[31] ? (~axis_speed + 32'h00000001) : axis_speed;
wire [32:0] away_dist = ovr_reg[1] ? (pos_x - {ref_pos_reg[31], ref_pos_reg})
                                   : ({ref_pos_reg[31], ref_pos_reg} - pos_x);

reg [31:0] dist_sel;
reg [63:0] prod;
reg [63:0] radicand;

// distance toward the limit in the direction of travel, clamped at zero
always @*
begin
    if (!sq_phase_reg)
        dist_sel = speed_up ? (slp_up[32] ? 32'h00000000 : slp_up[31:0])
                            : (slp_dn[32] ? 32'h00000000 : slp_dn[31:0]);
    else
        dist_sel = speed_up ? (smp_up[32] ? 32'h00000000 : smp_up[31:0])
                            : (smp_dn[32] ? 32'h00000000 : smp_dn[31:0]);
    prod = {32'h00000000, dist_sel} * {32'h00000000, decel_reg};
    radicand = prod[63] ? 64'hffffffffffffffff : {prod[62:0], 1'b0}; // saturating 2*d*a
end

// ----------------------------------------------------------------
// fault conditions
// ----------------------------------------------------------------
wire slp_active = slp_arm_reg && slp_req && (slp_cnt_reg == 39'h0000000000);
wire smp_mon = smp_used && homed_ok;
wire cfg_flt = (smp_used && ({1'b0, range_reg} < smp_wid) && !smp_wid[32]) ||
               (slp_req && ({1'b0, range_reg} < slp_wid) && !slp_wid[32]);
wire r01_flt = slp_req_edge && !homed_ok;
wire slp_flt = slp_active && (slp_out || trust_evt || slp_spd_flt_reg);
wire tmo_flt = tmo_run_reg && (tmo_cnt_reg == HOME_TMO_CYC - 40'd1);
wire smp_win = smp_mon && !restr_reg && (smp_above || smp_below);
wire smp_flt = smp_win || (smp_mon && smp_spd_flt_reg) ||
               (smp_used && homing_done && trust_evt);
wire restr_flt = restr_reg && !away_dist[32] &&
                 (away_dist[31:0] > pos_tol_reg);
wire ack_block = r01_flt || slp_flt || tmo_flt || restr_flt;
wire func_flt = ack_block || smp_flt;

// state transitions of the fail-safe machine
always @*
begin
    case (mon_state_reg)
        MS_RUN:
            if (cfg_flt)
                mon_state_next = MS_FS;
            else if (func_flt)
                mon_state_next = MS_FFS;
            else
                mon_state_next = MS_RUN;
        MS_FFS:
            if (cfg_flt)
                mon_state_next = MS_FS;
            else if (ack_edge && !ack_block)
                mon_state_next = MS_RUN;
            else
                mon_state_next = MS_FFS;
        MS_FS:
            mon_state_next = MS_FS;
        default:
            mon_state_next = MS_FS;
    endcase
end

wire ev_func = (mon_state_reg == MS_RUN) && (mon_state_next == MS_FFS);
wire ev_fs = (mon_state_reg != MS_FS) && (mon_state_next == MS_FS);
wire ev_ack = (mon_state_reg == MS_FFS) && (mon_state_next == MS_RUN);
wire [3:0] irq_ev = {tmo_flt, ev_ack, ev_fs, ev_func};

// ----------------------------------------------------------------
// square root engine for the speed limit
// ----------------------------------------------------------------
spwm_isqrt #(
    .RW(64)
) u_sqrt (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .start(sq_go_reg),
    .radicand(radicand),
    .busy(sq_busy),
    .done(sq_done),
    .root(sq_root)
);

// launch one limit evaluation per monitoring cycle, alternating windows
always @(posedge clk_sys or posedge sys_rst)
begin
    if (sys_rst)
    begin
        sq_go_reg <= 1'b0;
        sq_run_reg <= 1'b0;
        sq_phase_reg <= 1'b0;
        spd_cap_reg <= 32'h00000000;
        slp_spd_flt_reg <= 1'b0;
        smp_spd_flt_reg <= 1'b0;
    end
    else
    begin
        sq_go_reg <= !sq_run_reg && !sq_go_reg && !sq_busy;
        slp_spd_flt_reg <= 1'b0;
        smp_spd_flt_reg <= 1'b0;
        if (sq_go_reg)
        begin
            sq_run_reg <= 1'b1;
            spd_cap_reg <= speed_mag;
        end
        if (sq_done)
        begin
            sq_run_reg <= 1'b0;
            sq_phase_reg <= !sq_phase_reg;
            if (!sq_phase_reg)
                slp_spd_flt_reg <= spd_cap_reg > sq_root;
            else
                smp_spd_flt_reg <= spd_cap_reg > sq_root;
        end
    end
end

// ----------------------------------------------------------------
// monitor sequencing
// ----------------------------------------------------------------
always @(posedge clk_sys or posedge sys_rst)
begin
    if (sys_rst)
    begin
        pin_s1_reg <= `SPWM_RST_PINS;
        pin_s2_reg <= `SPWM_RST_PINS;
        pin_s3_reg <= `SPWM_RST_PINS;
        pin_reg <= `SPWM_RST_PINS;
        pin_prev_reg <= `SPWM_RST_PINS;
        homed_prev_reg <= 1'b0;
        trust_changed_reg <= 1'b0;
        slp_arm_reg <= 1'b0;
        slp_cnt_reg <= 39'h0000000000;
        tmo_run_reg <= 1'b0;
        tmo_cnt_reg <= 40'h0000000000;
        restr_reg <= 1'b0;
        ovr_reg <= 2'b00;
        ref_pos_reg <= 32'h00000000;
        mon_state_reg <= MS_RUN;
    end
    else
    begin
        pin_s1_reg <= {fault_ack, pulse_enable, position_trusted_status,
                       limited_position_request};
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
        pin_reg <= (pin_agree & pin_s3_reg) | (~pin_agree & pin_reg);
        pin_prev_reg <= pin_reg;
        homed_prev_reg <= homing_done;
        mon_state_reg <= mon_state_next;
        // trust change is remembered until the axis is homed again, a new change wins
        if (trust_evt && homing_done)
            trust_changed_reg <= 1'b1;
        else if (homing_done && !homed_prev_reg)
            trust_changed_reg <= 1'b0;
        // start delay for limited position monitoring
        if (!slp_req)
            slp_arm_reg <= 1'b0;
        else if (slp_req_edge && homed_ok)
        begin
            slp_arm_reg <= 1'b1;
            slp_cnt_reg <= slp_dly_cyc[38:0];
        end
        else if (slp_cnt_reg != 39'h0000000000)
            slp_cnt_reg <= slp_cnt_reg - 39'h0000000001;
        // homing timeout for the maximum position function
        if (!smp_used || homing_done || tmo_flt)
            tmo_run_reg <= 1'b0;
        else if (pulse_edge)
        begin
            tmo_run_reg <= 1'b1;
            tmo_cnt_reg <= 40'h0000000000;
        end
        else if (tmo_run_reg)
            tmo_cnt_reg <= tmo_cnt_reg + 40'h0000000001;
        // overrun side is caught when the window fault fires
        if (ev_func && smp_win)
            ovr_reg <= {smp_above, smp_below};
        if (ev_ack && (ovr_reg != 2'b00))
        begin
            restr_reg <= 1'b1;
            ref_pos_reg <= axis_position;
        end
        else if (restr_reg && !smp_above && !smp_below)
        begin
            restr_reg <= 1'b0;
            ovr_reg <= 2'b00;
        end
    end
end

// drive outputs follow the next state so they switch with it
always @(posedge clk_sys or posedge sys_rst)
begin
    if (sys_rst)
    begin
        torque_enable <= 1'b0;
        function_error_free_out <= 1'b0;
        max_position_active_status <= 1'b0;
        allow_pos_dir <= 1'b0;
        allow_neg_dir <= 1'b0;
        irq <= 1'b0;
    end
    else
    begin
        torque_enable <= mon_state_next == MS_RUN;
        function_error_free_out <= mon_state_next == MS_RUN;
        max_position_active_status <= smp_mon && (mon_state_next == MS_RUN);
        allow_pos_dir <= (mon_state_next == MS_RUN) && !(restr_reg && ovr_reg[1]);
        allow_neg_dir <= (mon_state_next == MS_RUN) && !(restr_reg && ovr_reg[0]);
        irq <= |(irq_stat_reg & irq_en_reg);
    end
end

// ----------------------------------------------------------------
// wishbone register file
// ----------------------------------------------------------------
function [31:0] lanes;
    input [31:0] old;
    input [31:0] upd;
    input [3:0] sel;
    integer i;
    begin
        for (i = 0; i < 4; i = i + 1)
            lanes[i*8 +: 8] = sel[i] ? upd[i*8 +: 8] : old[i*8 +: 8];
    end
endfunction

// read mux for the addressed word, unmapped reads return zero
reg [31:0] rd_data;
always @*
begin
    case (wb_adr_i)
        `SPWM_ADR_CTRL: rd_data = {31'h00000000, ctrl_reg};
        `SPWM_ADR_DECEL: rd_data = decel_reg;
        `SPWM_ADR_SLP_LO: rd_data = slp_lo_reg;
        `SPWM_ADR_SLP_HI: rd_data = slp_hi_reg;
        `SPWM_ADR_SMP_LO: rd_data = smp_lo_reg;
        `SPWM_ADR_SMP_HI: rd_data = smp_hi_reg;
        `SPWM_ADR_SPD_TOL: rd_data = spd_tol_reg;
        `SPWM_ADR_POS_TOL: rd_data = pos_tol_reg;
        `SPWM_ADR_SLP_DLY: rd_data = slp_dly_reg;
        `SPWM_ADR_RANGE: rd_data = range_reg;
        `SPWM_ADR_STATUS: rd_data = {22'h000000, ovr_reg, restr_reg, trust_changed_reg,
                                     tmo_run_reg, slp_active, smp_mon, homing_done,
                                     mon_state_reg};
        `SPWM_ADR_IRQ_STAT: rd_data = {28'h0000000, irq_stat_reg};
        `SPWM_ADR_IRQ_EN: rd_data = {28'h0000000, irq_en_reg};
        default: rd_data = 32'h00000000;
    endcase
end

// single-cycle answer, writes land on the edge that raises ack
always @(posedge clk_sys or posedge sys_rst)
begin
    if (sys_rst)
    begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
        ctrl_reg <= `SPWM_RST_CTRL;
        decel_reg <= `SPWM_RST_DECEL;
        slp_lo_reg <= `SPWM_RST_LIMIT;
        slp_hi_reg <= `SPWM_RST_LIMIT;
        smp_lo_reg <= `SPWM_RST_LIMIT;
        smp_hi_reg <= `SPWM_RST_LIMIT;
        spd_tol_reg <= `SPWM_RST_TOL;
        pos_tol_reg <= `SPWM_RST_TOL;
        slp_dly_reg <= `SPWM_RST_DLY;
        range_reg <= `SPWM_RST_RANGE;
        irq_en_reg <= `SPWM_RST_IRQ;
        irq_stat_reg <= `SPWM_RST_IRQ;
    end
    else
    begin
        wb_ack_o <= wb_req;
        wb_dat_o <= wb_req ? rd_data : 32'h00000000;
        // hardware events win over a clear in the same cycle
        if (wb_wr && (wb_adr_i == `SPWM_ADR_IRQ_CLR) && wb_sel_i[0])
            irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[3:0]) | irq_ev;
        else
            irq_stat_reg <= irq_stat_reg | irq_ev;
        if (wb_wr)
        begin
            case (wb_adr_i)
                `SPWM_ADR_CTRL:
                    if (wb_sel_i[0])
                        ctrl_reg <= wb_dat_i[`SPWM_CTRL_SMP_USED];
                `SPWM_ADR_DECEL: decel_reg <= lanes(decel_reg, wb_dat_i, wb_sel_i);
                `SPWM_ADR_SLP_LO: slp_lo_reg <= lanes(slp_lo_reg, wb_dat_i, wb_sel_i);
                `SPWM_ADR_SLP_HI: slp_hi_reg <= lanes(slp_hi_reg, wb_dat_i, wb_sel_i);
                `SPWM_ADR_SMP_LO: smp_lo_reg <= lanes(smp_lo_reg, wb_dat_i, wb_sel_i);
                `SPWM_ADR_SMP_HI: smp_hi_reg <= lanes(smp_hi_reg, wb_dat_i, wb_sel_i);
                `SPWM_ADR_SPD_TOL: spd_tol_reg <= lanes(spd_tol_reg, wb_dat_i, wb_sel_i);
                `SPWM_ADR_POS_TOL: pos_tol_reg <= lanes(pos_tol_reg, wb_dat_i, wb_sel_i);
                `SPWM_ADR_SLP_DLY: slp_dly_reg <= lanes(slp_dly_reg, wb_dat_i, wb_sel_i);
                `SPWM_ADR_RANGE: range_reg <= lanes(range_reg, wb_dat_i, wb_sel_i);
                `SPWM_ADR_IRQ_EN:
                    if (wb_sel_i[0])
                        irq_en_reg <= wb_dat_i[3:0];
                default: ;
            endcase
        end
    end
end

endmodule
